// ---- hw/dpc_host.sv ----
// Host-side controller that sequences array and flag cycles on one SRAM port.
module dpc_host
  import dpc_pkg::*;
(
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // Request side.
  input wire dpc_req_t REQ,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  // Answer side.
  output logic RSP_VALID,
  output logic [DATA_W-1:0] RSP_DATA,
  // SRAM port pins.
  output dpc_pins_t PINS,
  input wire logic [DATA_W-1:0] DQ_I
);

  dpc_regs_t q;
  dpc_regs_t d;

  // Lane mask for array reads, one bit per data line.
  function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] en);
    return {{9{en[1]}}, {9{en[0]}}};
  endfunction

  always_comb begin
    d = q;
    d.rvalid = 1'h0;
    // The pin sample passes two flops before the capture logic reads it.
    d.sync1 = DQ_I;
    d.sync2 = q.sync1;
    case (q.st)
      S_IDLE: begin
        // Idle keeps chip select high, so the device can sit in standby.
        d.pins = PINS_IDLE;
        d.pins.addr = q.pins.addr;
        if (REQ_VALID) begin
          d.cmd = REQ;
          // The address moves only while every strobe is high.
          d.pins.addr = REQ.addr;
          d.st = S_SETUP;
        end
      end
      S_SETUP: begin
        if (q.cmd.is_flag) begin
          // Chip select and both lanes stay high for a whole flag cycle.
          d.pins.flag_select_n = 1'h0;
        end else begin
          d.pins.chip_sel_n = 1'h0;
          d.pins.upper_lane_select_n = !q.cmd.lane_en[1];
          d.pins.lower_lane_select_n = !q.cmd.lane_en[0];
        end
        if (q.cmd.is_write) begin
          // Write falls together with the strobes and output enable stays
          // high, so the device outputs never turn on during the write.
          d.pins.rw_n = 1'h0;
          d.cnt = WR_LAST;
        end else begin
          d.pins.out_en_n = 1'h0;
          // The read wait always covers the busy-release delay, because this port
          // cannot see whether the opposite port is finishing a write to the same word.
          d.cnt = RD_LAST;
        end
        d.st = S_PULSE;
      end
      S_PULSE: begin
        if (q.cmd.is_write && (q.cnt <= DRV_AT)) begin
          // Data goes out only after the turnoff time of the device drivers.
          d.pins.dq_oe_n = 1'h0;
          d.pins.dq_o = q.cmd.is_flag ? {{(DATA_W-1){1'h0}}, q.cmd.wdata[0]}
                                      : q.cmd.wdata;
        end
        if (q.cnt == '0) begin
          d.pins.chip_sel_n = 1'h1;
          d.pins.rw_n = 1'h1;
          d.pins.out_en_n = 1'h1;
          d.pins.flag_select_n = 1'h1;
          d.pins.upper_lane_select_n = 1'h1;
          d.pins.lower_lane_select_n = 1'h1;
          if (!q.cmd.is_write) begin
            // A flag read shows its value on every line; bit 0 is taken.
            d.rdata = q.cmd.is_flag ? {DATA_W{q.sync2[0]}}
                                    : (q.sync2 & lane_mask(q.cmd.lane_en));
          end
          d.st = S_END;
        end else begin
          d.cnt = q.cnt - 1'h1;
        end
      end
      S_END: begin
        // Write data stood through the rising edge of the write line.
        d.pins.dq_oe_n = 1'h1;
        d.rvalid = !q.cmd.is_write;
        d.cnt = REC_LAST;
        d.st = S_RECOV;
      end
      S_RECOV: begin
        if (q.cnt == '0) begin
          d.st = S_IDLE;
        end else begin
          d.cnt = q.cnt - 1'h1;
        end
      end
      default: begin
        d.st = S_IDLE;
        d.pins = PINS_IDLE;
      end
    endcase
  end

  // Reset loads constants only, so a cycle cut short by reset leaves every strobe high.
  // The device is then deselected at once and may drop into standby.
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      q <= '{st: S_IDLE, cnt: '0, cmd: '0, pins: PINS_IDLE, rdata: '0,
             rvalid: 1'h0, sync1: '0, sync2: '0};
    end else begin
      q <= d;
    end
  end

  assign REQ_READY = (q.st == S_IDLE);
  assign RSP_VALID = q.rvalid;
  assign RSP_DATA = q.rdata;
  assign PINS = q.pins;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  sequence flag_strobe_s;
    !q.pins.flag_select_n;
  endsequence

  sequence flag_release_s;
    q.pins.flag_select_n [*2];
  endsequence

  flag_class_a: assert property (flag_strobe_s |-> q.pins.chip_sel_n &&
    q.pins.upper_lane_select_n && q.pins.lower_lane_select_n)
    else $error("flag cycle with array strobes active");

  array_class_a: assert property (!q.pins.chip_sel_n |-> q.pins.flag_select_n &&
    !(q.pins.upper_lane_select_n && q.pins.lower_lane_select_n))
    else $error("array cycle without a lane or with flag select");

  addr_move_a: assert property (!$stable(q.pins.addr) |->
    q.pins.rw_n && q.pins.chip_sel_n && $past(q.pins.rw_n))
    else $error("address moved while a write strobe was active");

  no_early_drive_a: assert property ($fell(q.pins.rw_n) |-> q.pins.dq_oe_n)
    else $error("data driven in the first write cycle");

  pulse_width_a: assert property ($fell(q.pins.rw_n) |-> !q.pins.rw_n [*2])
    else $error("write pulse shorter than required");

  data_hold_a: assert property ($rose(q.pins.rw_n) |-> !q.pins.dq_oe_n)
    else $error("write data released before the write ended");

  read_access_a: assert property ($fell(q.pins.out_en_n) |->
    !q.pins.out_en_n [*3] ##1 q.pins.out_en_n ##1 RSP_VALID)
    else $error("read answered before the access delay");

  flag_gap_a: assert property ($rose(q.pins.flag_select_n) |-> flag_release_s)
    else $error("flag select high for too short a gap");

  flag_fanout_a: assert property (RSP_VALID && q.cmd.is_flag |->
    (RSP_DATA == '0) || (RSP_DATA == '1))
    else $error("flag read answer not uniform across lines");

  sequence write_pulse_s;
    !q.pins.rw_n [*2];
  endsequence

  sequence write_tail_s;
    q.pins.rw_n && !q.pins.dq_oe_n;
  endsequence

  // The write line falls with its strobe, so the device outputs never turn on.
  write_start_a: assert property ($fell(q.pins.rw_n) |-> q.pins.out_en_n &&
    ($fell(q.pins.chip_sel_n) || $fell(q.pins.flag_select_n)))
    else $error("write line fell apart from its strobe");

  write_cycle_a: assert property ($fell(q.pins.rw_n) |->
    write_pulse_s ##1 write_tail_s)
    else $error("write pulse or data hold cut short");

  oe_in_write_a: assert property (!q.pins.rw_n |-> q.pins.out_en_n)
    else $error("output enable low during a write");

  drive_safe_a: assert property (!q.pins.dq_oe_n |-> q.pins.out_en_n)
    else $error("bus driven while device outputs enabled");

  addr_hold_a: assert property ((!q.pins.chip_sel_n || !q.pins.flag_select_n) |->
    $stable(q.pins.addr))
    else $error("address moved during an access");

  idle_quiet_a: assert property ((q.st == S_IDLE) |-> q.pins.chip_sel_n &&
    q.pins.flag_select_n && q.pins.dq_oe_n)
    else $error("strobe or data active in idle");

  answer_pulse_a: assert property (RSP_VALID |=> !RSP_VALID)
    else $error("read answer held longer than one cycle");

  // A flag write puts its bit on line 0 only; the other lines stay low.
  flag_data_a: assert property (!q.pins.flag_select_n && !q.pins.dq_oe_n |->
    (q.pins.dq_o[DATA_W-1:1] == '0))
    else $error("flag write drove lines above line 0");

endmodule

// ---- hw/dpc_pkg.sv ----
// Constants and types for the dual-port SRAM host-side access controller.
package dpc_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 18;
  localparam int CNT_W = 4;
  localparam int SYNC_STAGES = 2;

  // Clock period and device timing in nanoseconds (slower speed grade).
  localparam int CLK_NS = 50;
  localparam int T_WP_NS = 15;
  localparam int T_WZ_NS = 12;
  localparam int T_DW_NS = 15;
  localparam int T_AA_NS = 20;
  localparam int T_BDD_NS = 30;
  localparam int T_SOP_NS = 10;
  localparam int T_SWRD_NS = 5;

  // Least time rounded up to whole cycles, never below one cycle.
  function automatic int cyc_up(input int t_ns);
    int c;
    c = (t_ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int imax(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  localparam int WP_CYC = cyc_up(T_WP_NS);
  localparam int WZ_CYC = cyc_up(T_WZ_NS);
  localparam int DW_CYC = cyc_up(T_DW_NS);
  localparam int WR_CYC = imax(WP_CYC, WZ_CYC + DW_CYC);
  localparam int ACC_CYC = cyc_up(imax(T_AA_NS, T_BDD_NS));
  localparam int RD_CYC = ACC_CYC + SYNC_STAGES;
  localparam int REC_CYC = imax(cyc_up(T_SOP_NS), cyc_up(T_SWRD_NS));

  localparam logic [CNT_W-1:0] WR_LAST = CNT_W'(WR_CYC - 1);
  localparam logic [CNT_W-1:0] RD_LAST = CNT_W'(RD_CYC - 1);
  localparam logic [CNT_W-1:0] REC_LAST = CNT_W'(REC_CYC - 1);
  localparam logic [CNT_W-1:0] DRV_AT = CNT_W'(WR_CYC - WZ_CYC);

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_SETUP = 3'h1,
    S_PULSE = 3'h3,
    S_END = 3'h2,
    S_RECOV = 3'h6
  } dpc_state_t;

  typedef struct packed {
    logic is_write;
    logic is_flag;
    logic [ADDR_W-1:0] addr;
    logic [1:0] lane_en;
    logic [DATA_W-1:0] wdata;
  } dpc_req_t;

  typedef struct packed {
    logic chip_sel_n;
    logic rw_n;
    logic out_en_n;
    logic flag_select_n;
    logic upper_lane_select_n;
    logic lower_lane_select_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_o;
    logic dq_oe_n;
  } dpc_pins_t;

  typedef struct packed {
    dpc_state_t st;
    logic [CNT_W-1:0] cnt;
    dpc_req_t cmd;
    dpc_pins_t pins;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic [DATA_W-1:0] sync1;
    logic [DATA_W-1:0] sync2;
  } dpc_regs_t;

  localparam dpc_pins_t PINS_IDLE = '{
    chip_sel_n: 1'h1, rw_n: 1'h1, out_en_n: 1'h1, flag_select_n: 1'h1,
    upper_lane_select_n: 1'h1, lower_lane_select_n: 1'h1,
    addr: '0, dq_o: '0, dq_oe_n: 1'h1};

endpackage

// ---- sim/dpc_sram_model.sv ----
// Behavioural model of one SRAM port with its flags.
module dpc_sram_model
  import dpc_pkg::*;
(
  // Clock and port pins.
  input wire logic clk,
  input wire dpc_pins_t pins,
  // Resolved bus and device drive.
  output logic [DATA_W-1:0] dq,
  output logic dev_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [7:0] flag_ff = 8'h00;
  logic [DATA_W-1:0] last_ff = 18'h00000;
  logic [DATA_W-1:0] lane_m, dev_m, dev_d;
  logic arr_sel, flag_sel;
  assign lane_m = {{9{!pins.upper_lane_select_n}}, {9{!pins.lower_lane_select_n}}};
  assign arr_sel = !pins.chip_sel_n && lane_m != '0 && pins.flag_select_n;
  assign flag_sel = !pins.flag_select_n && (pins.chip_sel_n || lane_m == '0);
  // Outputs stay off while the write line is low, whichever strobe fell first.
  assign dev_drv = pins.rw_n && !pins.out_en_n && (arr_sel || flag_sel);
  // Only this port is modelled, so no opposite write delays a read or contends a flag.
  assign dev_d = flag_sel ? {DATA_W{flag_ff[pins.addr[2:0]]}} : mem[pins.addr];
  assign dev_m = dev_drv ? (flag_sel ? '1 : lane_m) : '0;
  // A released line has no pull, so it shows the inverse of its last level.
  assign dq = !pins.dq_oe_n ? pins.dq_o : ((dev_d & dev_m) | (~last_ff & ~dev_m));
  always @(posedge clk) begin
    last_ff <= dq;
    if (!pins.rw_n && arr_sel) mem[pins.addr] <= (mem[pins.addr] & ~lane_m) | (dq & lane_m);
    if (!pins.rw_n && flag_sel) flag_ff[pins.addr[2:0]] <= dq[0];
  end
endmodule

// ---- sim/dual_port_sram_access_cycles_test.sv ----
// Self-checking bench for the SRAM port controller.
module dual_port_sram_access_cycles_test;
  import dpc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    dpc_req_t req;
    logic [DATA_W-1:0] exp;
  } dpc_row_t;
  logic SYS_CLK, SYS_RST, REQ_VALID, REQ_READY, RSP_VALID, dev_drv;
  dpc_req_t REQ;
  logic [DATA_W-1:0] RSP_DATA, dq, seen;
  dpc_pins_t PINS, prev_pins;
  dpc_row_t rows [11];
  int miscompares = 0;
  int cmp_count = 0;
  int lo_cnt = 0;
  dpc_host u_dut (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .REQ(REQ), .REQ_VALID(REQ_VALID),
    .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA), .PINS(PINS), .DQ_I(dq));
  dpc_sram_model u_sram (.clk(SYS_CLK), .pins(PINS), .dq(dq), .dev_drv(dev_drv));
  initial begin
    SYS_CLK = 1'h0;
    forever #25 SYS_CLK = ~SYS_CLK;
  end
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  function automatic dpc_row_t mk(logic w, logic f, logic [11:0] a, logic [1:0] l,
      logic [17:0] d, logic [17:0] e);
    return '{'{w, f, a, l, d}, e};
  endfunction
  // Valid stays up between requests, so each new request is taken straight away.
  task automatic run(input dpc_req_t r, output logic [DATA_W-1:0] d);
    int k;
    int rsp_k;
    REQ = r;
    REQ_VALID = 1'h1;
    for (k = 0; k < 20 && REQ_READY !== 1'h1; k++) begin
      @(posedge SYS_CLK);
      #2;
    end
    @(posedge SYS_CLK);
    #2;
    k = 0;
    rsp_k = 0;
    d = '0;
    while (REQ_READY !== 1'h1 && k < 20) begin
      @(posedge SYS_CLK);
      #2;
      k++;
      if (RSP_VALID === 1'h1) begin
        rsp_k = k;
        d = RSP_DATA;
      end
    end
    check(DATA_W'(rsp_k), r.is_write ? 18'h0 : DATA_W'(2 + RD_CYC));
    check(DATA_W'(k), DATA_W'(2 + REC_CYC + (r.is_write ? WR_CYC : RD_CYC)));
  endtask
  always @(posedge SYS_CLK) begin
    if (!SYS_RST) begin
      check(DATA_W'(!dev_drv || PINS.dq_oe_n), 18'h1);
      check(DATA_W'(PINS.flag_select_n || PINS.chip_sel_n ||
        (PINS.upper_lane_select_n && PINS.lower_lane_select_n)), 18'h1);
      check(DATA_W'(PINS.addr == prev_pins.addr || (PINS.rw_n && prev_pins.rw_n)), 18'h1);
      if (PINS.rw_n && !prev_pins.rw_n) check(DATA_W'(lo_cnt >= WR_CYC), 18'h1);
    end
    lo_cnt <= PINS.rw_n ? 0 : lo_cnt + 1;
    prev_pins <= PINS;
  end
  initial begin
    #50000;
    miscompares++;
    $display("unexpected at %0t: watchdog expired", $time);
    report_and_stop();
  end
  initial begin
    SYS_RST = 1'h1;
    REQ_VALID = 1'h0;
    REQ = '0;
    rows = '{mk(1'h1, 1'h0, 12'hFFF, 2'h3, 18'h2AAAA, 18'h0),
      mk(1'h0, 1'h0, 12'hFFF, 2'h3, 18'h0, 18'h2AAAA),
      mk(1'h1, 1'h0, 12'hFFF, 2'h2, 18'h15555, 18'h0),
      mk(1'h0, 1'h0, 12'hFFF, 2'h3, 18'h0, 18'h154AA),
      mk(1'h0, 1'h0, 12'hFFF, 2'h1, 18'h0, 18'h000AA),
      mk(1'h1, 1'h0, 12'h000, 2'h3, 18'h00F0F, 18'h0),
      mk(1'h0, 1'h0, 12'h000, 2'h3, 18'h0, 18'h00F0F),
      mk(1'h1, 1'h1, 12'h005, 2'h0, 18'h00001, 18'h0),
      mk(1'h0, 1'h1, 12'h005, 2'h0, 18'h0, 18'h3FFFF),
      mk(1'h1, 1'h1, 12'h005, 2'h0, 18'h0, 18'h0),
      mk(1'h0, 1'h1, 12'h005, 2'h0, 18'h0, 18'h0)};
    repeat (16) @(posedge SYS_CLK);
    #2;
    check(DATA_W'(PINS === PINS_IDLE && RSP_VALID === 1'h0), 18'h1);
    SYS_RST = 1'h0;
    @(posedge SYS_CLK);
    #2;
    check(DATA_W'(REQ_READY), 18'h1);
    for (int i = 0; i < 11; i++) begin
      run(rows[i].req, seen);
      if (!rows[i].req.is_write) check(seen, rows[i].exp);
      $display("row %0d done", i);
    end
    REQ = rows[3].req;
    repeat (2) @(posedge SYS_CLK);
    #2;
    SYS_RST = 1'h1;
    REQ_VALID = 1'h0;
    @(posedge SYS_CLK);
    #2;
    check(DATA_W'(PINS === PINS_IDLE && RSP_VALID === 1'h0), 18'h1);
    SYS_RST = 1'h0;
    run(rows[3].req, seen);
    check(seen, 18'h154AA);
    $display("reset in mid read done");
    report_and_stop();
  end
endmodule
